// file: verilog/pam_pkg.sv
package pam_pkg;
    // Pin counts per port group
    localparam int P3_PINS = 2;
    localparam int P4_PINS = 3;
    localparam int P5_PINS = 6;
    localparam int NPINS   = P3_PINS + P4_PINS + P5_PINS;

    // Pin positions in the flat pin vector
    localparam int IX_P38 = 0;
    localparam int IX_P39 = 1;
    localparam int IX_P40 = 2;
    localparam int IX_P41 = 3;
    localparam int IX_P42 = 4;
    localparam int IX_P50 = 5;

    // Two-bit function codes {high,low}
    localparam logic [1:0] FC_00 = 2'h0;
    localparam logic [1:0] FC_01 = 2'h1;
    localparam logic [1:0] FC_10 = 2'h2;
    localparam logic [1:0] FC_11 = 2'h3;

    // Reset values of the selection registers
    localparam logic [NPINS-1:0] ALT_RST   = 11'h000;
    localparam logic [NPINS-1:0] FCLO_RST  = 11'h000;
    localparam logic [NPINS-1:0] FCHI_RST  = 11'h000;
    localparam logic [NPINS-1:0] LATCH_RST = 11'h000;
    localparam logic [NPINS-1:0] DIR_RST   = 11'h7ff;
    localparam logic [3:0]       ODR_RST   = 4'h0;

    // Per-pin configuration as seen by the pin cell
    typedef struct packed {
        logic       alt;
        logic [1:0] code;
        logic       latch;
        logic       dir_in;
    } pam_pincfg_t;

    // Peripheral-side outputs that reach the pins
    typedef struct packed {
        logic       uart2_txd;
        logic       i2c0_data_oe;
        logic       i2c0_clock_oe;
        logic       i2c1_data_oe;
        logic       i2c1_clock_oe;
        logic       cserial0_out;
        logic       cserial0_clock_o;
        logic       cserial0_clock_oe;
        logic [3:0] timerq_out;
        logic [5:0] rtout;
        logic       debug_data_out;
        logic       cserial2_out;
        logic       cserial2_clock_o;
        logic       cserial2_clock_oe;
    } pam_periph_out_t;

    // Pin-side inputs delivered to peripherals
    typedef struct packed {
        logic       uart2_rxd;
        logic       i2c0_data_in;
        logic       i2c0_clock_in;
        logic       i2c1_data_in;
        logic       i2c1_clock_in;
        logic       cserial0_in;
        logic       cserial0_clock_in;
        logic [3:0] timerq_in;
        logic [5:0] keyin;
        logic       debug_data_in;
        logic       debug_clock_in;
        logic       debug_mode_select;
        logic       cserial2_in;
        logic       cserial2_clock_in;
    } pam_periph_in_t;
endpackage

// file: verilog/pam_pin_cell.sv
`timescale 1ns/100ps
// One pin: chooses between port mode and an alternate function driver
module pam_pin_cell
(
    // Port-mode settings
    input  wire logic alt,
    input  wire logic latch,
    input  wire logic dir_in,
    // Alternate-function drive
    input  wire logic fn_o,
    input  wire logic fn_oe,
    // Pin
    output logic      pin_o,
    output logic      pin_oe
);
    // Latch and direction have no say once the alternate path is chosen
    always_comb
    begin
        if (alt)
        begin
            pin_o  = fn_o;
            pin_oe = fn_oe;
        end
        else
        begin
            pin_o  = latch;
            pin_oe = ~dir_in;
        end
    end
endmodule

// file: verilog/pam_port_mux.sv
`timescale 1ns/100ps
module pam_port_mux
(
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // Selection register writes
    input  wire logic                         cfg_we,
    input  wire logic [pam_pkg::NPINS-1:0]    alt_select_bit_wr,
    input  wire logic [pam_pkg::NPINS-1:0]    func_code_low_wr,
    input  wire logic [pam_pkg::NPINS-1:0]    func_code_high_wr,
    input  wire logic [pam_pkg::NPINS-1:0]    port_latch_wr,
    input  wire logic [pam_pkg::NPINS-1:0]    port_dir_in_wr,
    input  wire logic [3:0]                   open_drain_wr,
    input  wire logic                         debug_pin_takeover_wr,
    // Selection register readback
    output logic [pam_pkg::NPINS-1:0]         alt_select_bit,
    output logic [pam_pkg::NPINS-1:0]         func_code_low,
    output logic [pam_pkg::NPINS-1:0]         func_code_high,
    output logic [3:0]                        open_drain,
    output logic                              debug_pin_takeover,
    // Peripheral side
    input  wire pam_pkg::pam_periph_out_t     periph_o,
    output pam_pkg::pam_periph_in_t           periph_i,
    // Port-mode read data
    output logic [pam_pkg::NPINS-1:0]         port_read,
    // Pins
    input  wire logic [pam_pkg::NPINS-1:0]    pin_i,
    output logic [pam_pkg::NPINS-1:0]         pin_o,
    output logic [pam_pkg::NPINS-1:0]         pin_oe
);
    logic [pam_pkg::NPINS-1:0] alt_q;
    logic [pam_pkg::NPINS-1:0] fclo_q;
    logic [pam_pkg::NPINS-1:0] fchi_q;
    logic [pam_pkg::NPINS-1:0] latch_q;
    logic [pam_pkg::NPINS-1:0] dir_q;
    logic [3:0]                odr_q;
    logic                      dbg_q;
    logic [pam_pkg::NPINS-1:0] cell_alt;
    logic [pam_pkg::NPINS-1:0] fn_o;
    logic [pam_pkg::NPINS-1:0] fn_oe;

    // Open-drain drive: pull low only, release for a one
    function automatic logic od_oe(input logic od_en, input logic val);
        od_oe = od_en & ~val;
    endfunction

    // Function code of a pin
    function automatic logic [1:0] code_of(input int ix,
                                           input logic [pam_pkg::NPINS-1:0] hi,
                                           input logic [pam_pkg::NPINS-1:0] lo);
        code_of = {hi[ix], lo[ix]};
    endfunction

    // Selection registers, written as a whole by the bus side
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            alt_q   <= pam_pkg::ALT_RST;
            fclo_q  <= pam_pkg::FCLO_RST;
            fchi_q  <= pam_pkg::FCHI_RST;
            latch_q <= pam_pkg::LATCH_RST;
            dir_q   <= pam_pkg::DIR_RST;
        end
        else if (cfg_we)
        begin
            alt_q   <= alt_select_bit_wr;
            fclo_q  <= func_code_low_wr;
            fchi_q  <= func_code_high_wr;
            latch_q <= port_latch_wr;
            dir_q   <= port_dir_in_wr;
        end
    end

    // Open-drain and debug takeover bits
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            odr_q <= pam_pkg::ODR_RST;
            dbg_q <= 1'b0;
        end
        else if (cfg_we)
        begin
            odr_q <= open_drain_wr;
            dbg_q <= debug_pin_takeover_wr;
        end
    end

    assign alt_select_bit     = alt_q;
    assign func_code_low      = fclo_q;
    assign func_code_high     = fchi_q;
    assign open_drain         = odr_q;
    assign debug_pin_takeover = dbg_q;

    // Debug pins act as alternate pins whatever alt select says
    always_comb
    begin
        cell_alt = alt_q;
        if (dbg_q)
        begin
            cell_alt[pam_pkg::IX_P50+2] = 1'b1;
            cell_alt[pam_pkg::IX_P50+3] = 1'b1;
            cell_alt[pam_pkg::IX_P50+4] = 1'b1;
            cell_alt[pam_pkg::IX_P50+5] = 1'b1;
        end
    end

    // Output side selection per pin
    always_comb
    begin
        logic [1:0] c;
        c     = 2'h0;
        fn_o  = '0;
        fn_oe = '0;
        // I2C needs open drain; with it clear the pin stays released
        if (fclo_q[pam_pkg::IX_P38] == 1'b0)
        begin
            fn_o[pam_pkg::IX_P38]  = periph_o.uart2_txd;
            fn_oe[pam_pkg::IX_P38] = 1'b1;
        end
        else
        begin
            fn_oe[pam_pkg::IX_P38] = od_oe(odr_q[0], ~periph_o.i2c0_data_oe);
        end
        if (fclo_q[pam_pkg::IX_P39] == 1'b1)
        begin
            fn_oe[pam_pkg::IX_P39] = od_oe(odr_q[1], ~periph_o.i2c0_clock_oe);
        end
        if (fclo_q[pam_pkg::IX_P40] == 1'b1)
        begin
            fn_oe[pam_pkg::IX_P40] = od_oe(odr_q[2], ~periph_o.i2c1_data_oe);
        end
        if (fclo_q[pam_pkg::IX_P41] == 1'b0)
        begin
            fn_o[pam_pkg::IX_P41]  = periph_o.cserial0_out;
            fn_oe[pam_pkg::IX_P41] = 1'b1;
        end
        else
        begin
            fn_oe[pam_pkg::IX_P41] = od_oe(odr_q[3], ~periph_o.i2c1_clock_oe);
        end
        fn_o[pam_pkg::IX_P42]  = periph_o.cserial0_clock_o;
        fn_oe[pam_pkg::IX_P42] = periph_o.cserial0_clock_oe;
        // Port 5 bits 0..2: timer output and real-time output
        for (int k = 0; k < 3; k++)
        begin
            c = code_of(pam_pkg::IX_P50 + k, fchi_q, fclo_q);
            // Debug data input on P5.2 must stay released whatever its code says
            if (dbg_q && k == 2)
            begin
                fn_oe[pam_pkg::IX_P50+k] = 1'b0;
            end
            else if (c == pam_pkg::FC_10)
            begin
                fn_o[pam_pkg::IX_P50+k]  = periph_o.timerq_out[k+1];
                fn_oe[pam_pkg::IX_P50+k] = 1'b1;
            end
            else if (c == pam_pkg::FC_11)
            begin
                fn_o[pam_pkg::IX_P50+k]  = periph_o.rtout[k];
                fn_oe[pam_pkg::IX_P50+k] = 1'b1;
            end
        end
        c = code_of(pam_pkg::IX_P50 + 3, fchi_q, fclo_q);
        if (dbg_q)
        begin
            fn_o[pam_pkg::IX_P50+3]  = periph_o.debug_data_out;
            fn_oe[pam_pkg::IX_P50+3] = 1'b1;
        end
        else if (c == pam_pkg::FC_10)
        begin
            fn_o[pam_pkg::IX_P50+3]  = periph_o.timerq_out[0];
            fn_oe[pam_pkg::IX_P50+3] = 1'b1;
        end
        else if (c == pam_pkg::FC_11)
        begin
            fn_o[pam_pkg::IX_P50+3]  = periph_o.rtout[3];
            fn_oe[pam_pkg::IX_P50+3] = 1'b1;
        end
        c = code_of(pam_pkg::IX_P50 + 4, fchi_q, fclo_q);
        if (!dbg_q && c == pam_pkg::FC_00)
        begin
            fn_o[pam_pkg::IX_P50+4]  = periph_o.cserial2_out;
            fn_oe[pam_pkg::IX_P50+4] = 1'b1;
        end
        else if (!dbg_q && c == pam_pkg::FC_11)
        begin
            fn_o[pam_pkg::IX_P50+4]  = periph_o.rtout[4];
            fn_oe[pam_pkg::IX_P50+4] = 1'b1;
        end
        c = code_of(pam_pkg::IX_P50 + 5, fchi_q, fclo_q);
        if (!dbg_q && c == pam_pkg::FC_00)
        begin
            fn_o[pam_pkg::IX_P50+5]  = periph_o.cserial2_clock_o;
            fn_oe[pam_pkg::IX_P50+5] = periph_o.cserial2_clock_oe;
        end
        else if (!dbg_q && c == pam_pkg::FC_11)
        begin
            fn_o[pam_pkg::IX_P50+5]  = periph_o.rtout[5];
            fn_oe[pam_pkg::IX_P50+5] = 1'b1;
        end
    end

    // Pin cells; alt clear keeps the ordinary port path, except on P5.2 to P5.5 under debug takeover
    for (genvar g = 0; g < pam_pkg::NPINS; g++)
    begin : g_cell
        pam_pin_cell u_cell
        (
            .alt    (cell_alt[g]),
            .latch  (latch_q[g]),
            .dir_in (dir_q[g]),
            .fn_o   (fn_o[g]),
            .fn_oe  (fn_oe[g]),
            .pin_o  (pin_o[g]),
            .pin_oe (pin_oe[g])
        );
    end

    // Port read shows the pin level in input mode, the latch otherwise
    assign port_read = (pin_i & dir_q) | (latch_q & ~dir_q);

    // Input routing: unselected inputs idle high so serial lines see mark
    always_comb
    begin
        logic [1:0] c;
        c        = 2'h0;
        periph_i = '1;
        if (alt_q[pam_pkg::IX_P39] && !fclo_q[pam_pkg::IX_P39])
            periph_i.uart2_rxd = pin_i[pam_pkg::IX_P39];
        if (alt_q[pam_pkg::IX_P38] && fclo_q[pam_pkg::IX_P38])
            periph_i.i2c0_data_in = pin_i[pam_pkg::IX_P38];
        if (alt_q[pam_pkg::IX_P39] && fclo_q[pam_pkg::IX_P39])
            periph_i.i2c0_clock_in = pin_i[pam_pkg::IX_P39];
        if (alt_q[pam_pkg::IX_P40] && !fclo_q[pam_pkg::IX_P40])
            periph_i.cserial0_in = pin_i[pam_pkg::IX_P40];
        if (alt_q[pam_pkg::IX_P40] && fclo_q[pam_pkg::IX_P40])
            periph_i.i2c1_data_in = pin_i[pam_pkg::IX_P40];
        if (alt_q[pam_pkg::IX_P41] && fclo_q[pam_pkg::IX_P41])
            periph_i.i2c1_clock_in = pin_i[pam_pkg::IX_P41];
        if (alt_q[pam_pkg::IX_P42])
            periph_i.cserial0_clock_in = pin_i[pam_pkg::IX_P42];
        // Timer input and key input share a pin; software keeps one idle
        for (int k = 0; k < 4; k++)
        begin
            c = code_of(pam_pkg::IX_P50 + k, fchi_q, fclo_q);
            if (alt_q[pam_pkg::IX_P50+k] && c == pam_pkg::FC_01 && !(dbg_q && k >= 2))
            begin
                periph_i.timerq_in[(k+1)%4] = pin_i[pam_pkg::IX_P50+k];
                periph_i.keyin[k] = pin_i[pam_pkg::IX_P50+k];
            end
        end
        for (int k = 4; k < 6; k++)
        begin
            c = code_of(pam_pkg::IX_P50 + k, fchi_q, fclo_q);
            if (alt_q[pam_pkg::IX_P50+k] && !dbg_q && c == pam_pkg::FC_01)
                periph_i.keyin[k] = pin_i[pam_pkg::IX_P50+k];
        end
        c = code_of(pam_pkg::IX_P50 + 3, fchi_q, fclo_q);
        if (alt_q[pam_pkg::IX_P50+3] && !dbg_q && c == pam_pkg::FC_00)
            periph_i.cserial2_in = pin_i[pam_pkg::IX_P50+3];
        c = code_of(pam_pkg::IX_P50 + 5, fchi_q, fclo_q);
        if (alt_q[pam_pkg::IX_P50+5] && !dbg_q && c == pam_pkg::FC_00)
            periph_i.cserial2_clock_in = pin_i[pam_pkg::IX_P50+5];
        if (dbg_q)
        begin
            periph_i.debug_data_in     = pin_i[pam_pkg::IX_P50+2];
            periph_i.debug_clock_in    = pin_i[pam_pkg::IX_P50+4];
            periph_i.debug_mode_select = pin_i[pam_pkg::IX_P50+5];
        end
    end
endmodule

// file: tb/pam_port_mux_sva.sv
`timescale 1ns/100ps
// Port-level checks of the pin mux; combinational routes are judged at every rising mclk edge outside reset
module pam_port_mux_chk
(
    // Clock and reset
    input wire logic                      mclk,
    input wire logic                      rst,
    // Register side
    input wire logic                      cfg_we,
    input wire logic [pam_pkg::NPINS-1:0] alt_select_bit_wr,
    input wire logic [pam_pkg::NPINS-1:0] port_latch_wr,
    input wire logic [pam_pkg::NPINS-1:0] port_dir_in_wr,
    input wire logic [pam_pkg::NPINS-1:0] alt_select_bit,
    input wire logic [pam_pkg::NPINS-1:0] func_code_low,
    input wire logic [pam_pkg::NPINS-1:0] func_code_high,
    input wire logic [3:0]                open_drain,
    input wire logic                      debug_pin_takeover,
    // Peripheral and pin side
    input wire pam_pkg::pam_periph_out_t  periph_o,
    input wire pam_pkg::pam_periph_in_t   periph_i,
    input wire logic [pam_pkg::NPINS-1:0] pin_i,
    input wire logic [pam_pkg::NPINS-1:0] pin_o,
    input wire logic [pam_pkg::NPINS-1:0] pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_uart_tx_route: assert property (
        alt_select_bit[0] && !func_code_low[0] |-> pin_oe[0] && pin_o[0] == periph_o.uart2_txd)
        else $error("uart2 transmit not on its pin");
    a_i2c_data_od: assert property (
        alt_select_bit[0] && func_code_low[0] && open_drain[0]
        |-> pin_oe[0] == periph_o.i2c0_data_oe && !(pin_oe[0] && pin_o[0]))
        else $error("i2c0 data not driven open drain");
    a_cser_clk_pin: assert property (
        alt_select_bit[4] |-> pin_oe[4] == periph_o.cserial0_clock_oe
        && periph_i.cserial0_clock_in == pin_i[4])
        else $error("cserial0 clock pin misrouted");
    a_timer_out_route: assert property (
        alt_select_bit[5] && {func_code_high[5], func_code_low[5]} == 2'h2
        |-> pin_oe[5] && pin_o[5] == periph_o.timerq_out[1])
        else $error("timer channel 1 output not on pin");
    a_key_timer_in: assert property (
        alt_select_bit[5] && {func_code_high[5], func_code_low[5]} == 2'h1
        |-> !pin_oe[5] && periph_i.keyin[0] == pin_i[5] && periph_i.timerq_in[1] == pin_i[5])
        else $error("key 0 or timer 1 input not fed");
    a_rtout_route: assert property (
        alt_select_bit[8] && func_code_high[8] && func_code_low[8] && !debug_pin_takeover
        |-> pin_oe[8] && pin_o[8] == periph_o.rtout[3])
        else $error("real-time output 3 not on pin");
    a_debug_data_out: assert property (
        debug_pin_takeover |-> pin_oe[8] && pin_o[8] == periph_o.debug_data_out)
        else $error("debug data output not on pin");
    a_debug_inputs: assert property (
        debug_pin_takeover |-> pin_oe[10:9] == 2'h0 && !pin_oe[7]
        && {periph_i.debug_data_in, periph_i.debug_clock_in, periph_i.debug_mode_select}
        == {pin_i[7], pin_i[9], pin_i[10]})
        else $error("debug inputs not taken from pins");
    a_port_drive: assert property (
        cfg_we && !alt_select_bit_wr[2] && !port_dir_in_wr[2]
        |=> pin_oe[2] && pin_o[2] == $past(port_latch_wr[2]))
        else $error("port output does not follow latch");
endmodule

bind pam_port_mux pam_port_mux_chk u_chk
(
    .mclk, .rst, .cfg_we, .alt_select_bit_wr, .port_latch_wr, .port_dir_in_wr,
    .alt_select_bit, .func_code_low, .func_code_high, .open_drain,
    .debug_pin_takeover, .periph_o, .periph_i, .pin_i, .pin_o, .pin_oe
);

// file: tb/pam_periph_model.sv
`timescale 1ns/100ps
// Peripherals and board as seen from the pins
module pam_periph_model
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Pin drive from the mux and from the board
    input  wire logic [pam_pkg::NPINS-1:0] pin_o,
    input  wire logic [pam_pkg::NPINS-1:0] pin_oe,
    input  wire logic [pam_pkg::NPINS-1:0] ext_val,
    // Peripheral side
    output pam_pkg::pam_periph_out_t       periph_o,
    output logic [pam_pkg::NPINS-1:0]      pin_i
);
    localparam int W = $bits(pam_pkg::pam_periph_out_t);
    logic [W-1:0] pat_q;

    // Moving pattern, so a stale route shows up; no key enable or capture edge exists here
    always_ff @(posedge mclk)
    begin
        if (rst)
            pat_q <= '0;
        else
            pat_q <= {pat_q[W-2:0], ~pat_q[W-1]};
    end
    assign periph_o = pam_pkg::pam_periph_out_t'(pat_q);
    // The mux wins where it drives, otherwise the board level shows through
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
    logic                     mclk = 1'b0;
    logic                     rst = 1'b1;
    logic                     cfg_we = 1'b0;
    logic [10:0]              alt_w = '0, lo_w = '0, hi_w = '0, lat_w = '0, dir_w = '1;
    logic [10:0]              ext_val = '0;
    logic [3:0]               odr_w = '0;
    logic                     dbg_w = 1'b0;
    logic [10:0]              alt_r, lo_r, hi_r, port_read, pin_i, pin_o, pin_oe;
    logic [3:0]               odr_r;
    logic                     dbg_r;
    pam_pkg::pam_periph_out_t periph_o;
    pam_pkg::pam_periph_in_t  periph_i;
    int                       miscompares = 0, n_checks = 0, cyc = 0;

    pam_port_mux dut
    (
        .mclk, .rst, .cfg_we, .alt_select_bit_wr(alt_w), .func_code_low_wr(lo_w),
        .func_code_high_wr(hi_w), .port_latch_wr(lat_w), .port_dir_in_wr(dir_w),
        .open_drain_wr(odr_w), .debug_pin_takeover_wr(dbg_w), .alt_select_bit(alt_r),
        .func_code_low(lo_r), .func_code_high(hi_r), .open_drain(odr_r),
        .debug_pin_takeover(dbg_r), .periph_o, .periph_i, .port_read, .pin_i, .pin_o, .pin_oe
    );
    pam_periph_model u_far (.mclk, .rst, .pin_o, .pin_oe, .ext_val, .periph_o, .pin_i);

    always #20 mclk = ~mclk;
    // Board levels move every cycle; a hang is cut short well past the expected run
    always @(posedge mclk)
    begin
        ext_val <= ext_val + 11'h135;
        cyc++;
        if (cyc > 2000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // A write leaves cfg_we high, so two calls in a row give back-to-back writes
    task automatic wr(input logic [10:0] a, l, h, lt, d, input logic [3:0] od, input logic dg);
        @(posedge mclk);
        alt_w <= a;
        lo_w <= l;
        hi_w <= h;
        lat_w <= lt;
        dir_w <= d;
        odr_w <= od;
        dbg_w <= dg;
        cfg_we <= 1'b1;
    endtask

    task automatic settle;
        @(posedge mclk);
        cfg_we <= 1'b0;
        @(negedge mclk);
    endtask

    // Port 3 and 4 pins, latch and direction set the opposite way
    task automatic t_p34;
        for (int l = 0; l < 2; l++)
        begin
            wr(11'h01f, {11{l[0]}}, '0, 11'h01f, '0, 4'hf, 1'b0);
            settle();
            if (l == 0)
            begin
                chk({pin_oe[0], pin_o[0]}, {1'b1, periph_o.uart2_txd}, "txd");
                chk(periph_i.uart2_rxd, pin_i[1], "rxd");
                chk(periph_i.cserial0_in, pin_i[2], "sin0");
                chk({pin_oe[3], pin_o[3]}, {1'b1, periph_o.cserial0_out}, "sout0");
            end
            else
            begin
                chk(pin_oe[0], periph_o.i2c0_data_oe, "sda0");
                chk(periph_i.i2c0_clock_in, pin_i[1], "scl0");
                chk(periph_i.i2c1_data_in, pin_i[2], "sda1");
                chk(pin_oe[3], periph_o.i2c1_clock_oe, "scl1");
                chk({pin_oe[1], pin_oe[2]}, {periph_o.i2c0_clock_oe, periph_o.i2c1_data_oe},
                    "od oe");
                chk(pin_o[3:0] & pin_oe[3:0], 4'h0, "od low");
                chk({periph_i.i2c0_data_in, periph_i.i2c1_clock_in}, {pin_i[0], pin_i[3]},
                    "od in");
                chk(odr_r, 4'hf, "od rb");
            end
            chk(periph_i.cserial0_clock_in, pin_i[4], "sck0");
        end
    endtask

    // Every function code on every port 5 pin
    task automatic t_p5;
        logic [5:0] oe_x;
        logic [5:0] o_x;
        for (int c = 0; c < 4; c++)
        begin
            wr(11'h7e0, {{6{c[0]}}, 5'h00}, {{6{c[1]}}, 5'h00}, '0, '1, 4'h0, 1'b0);
            settle();
            case (c)
                0: oe_x = {periph_o.cserial2_clock_oe, 5'h10};
                1: oe_x = 6'h00;
                2: oe_x = 6'h0f;
                default: oe_x = 6'h3f;
            endcase
            o_x = (c == 2) ? {2'h0, periph_o.timerq_out[0], periph_o.timerq_out[3:1]}
                : (c == 3) ? periph_o.rtout
                : {periph_o.cserial2_clock_o, periph_o.cserial2_out, 4'h0};
            chk(pin_oe[10:5], oe_x, "p5 oe");
            chk(pin_o[10:5] & oe_x, o_x & oe_x, "p5 out");
            if (c == 1)
                chk({periph_i.keyin, periph_i.timerq_in},
                    {pin_i[10:5], pin_i[7:5], pin_i[8]}, "key");
            if (c == 0)
                chk({periph_i.cserial2_in, periph_i.cserial2_clock_in},
                    {pin_i[8], pin_i[10]}, "sin2");
        end
    endtask

    // Takeover over alternate settings, then over port-mode outputs
    task automatic t_debug;
        wr(11'h7e0, '1, '1, '1, '0, 4'h0, 1'b1);
        settle();
        chk({pin_oe[8], pin_o[8]}, {1'b1, periph_o.debug_data_out}, "ddo");
        chk({pin_oe[10:9], pin_oe[7]}, 3'h0, "dbg oe");
        chk({periph_i.debug_data_in, periph_i.debug_clock_in, periph_i.debug_mode_select},
            {pin_i[7], pin_i[9], pin_i[10]}, "dbg in");
        chk({pin_oe[5], pin_o[5]}, {1'b1, periph_o.rtout[0]}, "p50 kept");
        chk(dbg_r, 1'b1, "dbg rb");
        wr('0, '0, '0, '1, '0, 4'h0, 1'b1);
        settle();
        chk(pin_oe[10:7], 4'h2, "dbg port");
    endtask

    // Back-to-back writes; codes are left set but the alternate bit is clear
    task automatic t_port;
        wr('1, '1, '1, '0, '0, 4'hf, 1'b1);
        wr('0, '1, '1, 11'h2aa, 11'h0f0, 4'h0, 1'b0);
        settle();
        chk({alt_r, lo_r, hi_r, odr_r, dbg_r}, {11'h000, 11'h7ff, 11'h7ff, 5'h00}, "rb");
        chk(pin_oe, 11'h70f, "port oe");
        chk(pin_o & 11'h70f, 11'h20a, "port out");
        chk(port_read, (pin_i & 11'h0f0) | 11'h20a, "port rd");
    endtask

    // Reset in mid-run, with a write offered during it
    task automatic t_rst2;
        wr('1, '0, '1, '0, '0, 4'hf, 1'b1);
        settle();
        @(posedge mclk);
        rst <= 1'b1;
        cfg_we <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        cfg_we <= 1'b0;
        @(negedge mclk);
        chk({alt_r, hi_r, odr_r, dbg_r, pin_oe}, '0, "reset");
    endtask

    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({alt_r, pin_oe}, '0, "after reset");
        t_p34();
        t_p5();
        t_debug();
        t_port();
        t_rst2();
        print_verdict();
    end
endmodule
